// >>> rtl/gated_sixteen_bit_timer.sv
// The AXI4-Lite register port and the address map are this design's own decisions.
`timescale 1ns/1ps
module gated_sixteen_bit_timer (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write address and data
    input wire logic [timer_gate_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read
    input wire logic [timer_gate_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Pins and neighbouring logic
    input wire logic gate_pin,
    input wire logic comparator_gate_output,
    input wire logic ext_clock_pin,
    input wire logic [7:0] companion_8bit_timer,
    input wire logic sleep_active,
    // Core requests
    output logic irq_request,
    output logic wake_request
);

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    timer_gate_pkg::ctrl_t ctrl_reg;       // Timer control
    timer_gate_pkg::gate_cfg_t gcfg_reg;   // Gate configuration
    timer_gate_pkg::irq_en_t ien_reg;      // Interrupt enables
    logic [1:0] gate_source_select_reg;    // Gate source
    logic single_pulse_arm_reg;            // Arm, cleared by hardware
    logic [15:0] count_reg;                // The counter
    logic overflow_flag_reg;               // Sticky wrap flag
    logic gate_event_flag_reg;             // Sticky gate-fall flag
    logic gate_value_reg;                  // Gate value status
    logic toggle_ff_reg;                   // Gate toggle flip-flop
    timer_gate_pkg::sp_state_t sp_reg;     // Single-pulse state
    logic [2:0] sync1_reg;                 // First synchroniser stage
    logic [2:0] sync2_reg;                 // Second synchroniser stage
    logic ext_clk_prev_reg;                // External clock history
    logic comp_hold_reg;                   // Comparator sampled on ticks
    logic [7:0] companion_prev_reg;        // Companion timer history
    logic companion_pulse_reg;             // Wrap pulse
    logic pol_prev_reg;                    // Polarity-corrected history

    // ----------------------------------------
    // Bus wiring
    // ----------------------------------------
    logic [timer_gate_pkg::ADDR_W-1:0] waddr_reg; // Captured address
    logic [31:0] wdata_reg;                // Captured data
    logic [3:0] wstrb_reg;                 // Captured strobes
    logic do_write;                        // Both halves present
    logic wr_ctrl, wr_gate, wr_count, wr_flag, wr_ien;
    logic wr_hit;                          // Write address mapped

    assign do_write = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
    assign wr_ctrl = do_write && waddr_reg == timer_gate_pkg::CTRL_OFS;
    assign wr_gate = do_write && waddr_reg == timer_gate_pkg::GATE_OFS;
    assign wr_count = do_write && waddr_reg == timer_gate_pkg::COUNT_OFS;
    assign wr_flag = do_write && waddr_reg == timer_gate_pkg::FLAG_OFS;
    assign wr_ien = do_write && waddr_reg == timer_gate_pkg::IEN_OFS;
    assign wr_hit = wr_ctrl || wr_gate || wr_count || wr_flag || wr_ien;

    // Write channels: either may come first, reply one cycle after both
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= timer_gate_pkg::RESP_OKAY;
            waddr_reg <= '0;
            wdata_reg <= 32'h0000_0000;
            wstrb_reg <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                // Word-align the address
                waddr_reg <= {s_axi_awaddr[timer_gate_pkg::ADDR_W-1:2], 2'b00};
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wdata_reg <= s_axi_wdata;
                wstrb_reg <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (do_write) begin
                // Unmapped address answers an error, stores nothing
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_hit ? timer_gate_pkg::RESP_OKAY
                                      : timer_gate_pkg::RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    // Read channel: data one cycle after address, reserved bits zero
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= timer_gate_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= timer_gate_pkg::RESP_OKAY;
            case ({s_axi_araddr[timer_gate_pkg::ADDR_W-1:2], 2'b00})
                timer_gate_pkg::CTRL_OFS: s_axi_rdata <= {28'h000_0000, ctrl_reg};
                timer_gate_pkg::GATE_OFS: begin
                    s_axi_rdata <= {24'h00_0000, gcfg_reg, single_pulse_arm_reg,
                                    gate_value_reg, gate_source_select_reg};
                end
                // Count lives in this clock domain, so both bytes are stable
                timer_gate_pkg::COUNT_OFS: s_axi_rdata <= {16'h0000, count_reg};
                timer_gate_pkg::FLAG_OFS: begin
                    s_axi_rdata <= {30'h000_0000, overflow_flag_reg, gate_event_flag_reg};
                end
                timer_gate_pkg::IEN_OFS: s_axi_rdata <= {28'h000_0000, ien_reg};
                default: begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= timer_gate_pkg::RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // Configuration registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_reg <= '0;
            gcfg_reg <= '0;
            ien_reg <= '0;
            gate_source_select_reg <= timer_gate_pkg::GSS_PIN;
        end else begin
            if (wr_ctrl && wstrb_reg[0]) ctrl_reg <= wdata_reg[3:0];
            if (wr_gate && wstrb_reg[0]) begin
                gcfg_reg <= wdata_reg[7:4];
                gate_source_select_reg <= wdata_reg[1:0];
            end
            if (wr_ien && wstrb_reg[0]) ien_reg <= wdata_reg[3:0];
        end
    end

    // ----------------------------------------
    // Input synchronisers
    // ----------------------------------------
    // Pins and comparator are asynchronous: two stages before any use
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sync1_reg <= 3'h0;
            sync2_reg <= 3'h0;
        end else begin
            sync1_reg <= {ext_clock_pin, comparator_gate_output, gate_pin};
            sync2_reg <= sync1_reg;
        end
    end

    logic ext_rise;   // Rising edge of the external clock
    logic tick;       // Clock-source edge for the counter
    logic sleep_ok;   // Counting allowed in the current power state
    assign ext_rise = sync2_reg[2] && !ext_clk_prev_reg;
    assign tick = ctrl_reg.clock_source_select ? ext_rise : 1'b1;
    // In sleep only the unsynchronised external counter keeps running
    assign sleep_ok = !sleep_active
                   || (ctrl_reg.clock_source_select && ctrl_reg.no_sync_control);

    // ----------------------------------------
    // Gate source selection
    // ----------------------------------------
    logic src_lvl;    // Selected raw source
    logic pol_lvl;    // Source corrected for polarity
    logic pol_rise;   // Incrementing edge of the gate
    logic pol_fall;   // Trailing edge of the gate
    logic tgl_lvl;    // After optional toggle stage
    logic gate_val;   // Final gate level

    always_comb begin
        case (gate_source_select_reg)
            timer_gate_pkg::GSS_PIN: src_lvl = sync2_reg[0];
            timer_gate_pkg::GSS_COMPANION: src_lvl = companion_pulse_reg;
            timer_gate_pkg::GSS_COMPARATOR: begin
                // Sampled on counter ticks, or passed through as is
                src_lvl = ctrl_reg.comp_sync ? comp_hold_reg : sync2_reg[1];
            end
            default: src_lvl = 1'b0; // Reserved code gates nothing
        endcase
    end

    // Polarity folded in so downstream logic sees active-high
    assign pol_lvl = src_lvl ^ !gcfg_reg.gate_polarity;
    assign pol_rise = pol_lvl && !pol_prev_reg;
    assign pol_fall = !pol_lvl && pol_prev_reg;
    assign tgl_lvl = gcfg_reg.gate_toggle_mode ? toggle_ff_reg : pol_lvl;
    // Single-pulse gating sits behind the toggle stage, so both combine
    assign gate_val = gcfg_reg.gate_single_pulse_mode ? (sp_reg == timer_gate_pkg::SP_ACTIVE)
                                                      : tgl_lvl;

    // Edge history and companion wrap detection
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ext_clk_prev_reg <= 1'b0;
            pol_prev_reg <= 1'b0;
            companion_prev_reg <= 8'h00;
            companion_pulse_reg <= 1'b0;
            comp_hold_reg <= 1'b0;
        end else begin
            ext_clk_prev_reg <= sync2_reg[2];
            pol_prev_reg <= pol_lvl;
            companion_prev_reg <= companion_8bit_timer;
            // One-cycle high pulse when the companion wraps to zero
            companion_pulse_reg <= companion_prev_reg == timer_gate_pkg::COMPANION_MAX
                                && companion_8bit_timer == 8'h00;
            if (tick) comp_hold_reg <= sync2_reg[1];
        end
    end

    // Toggle flip-flop, held clear when unused or timer is off
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            toggle_ff_reg <= 1'b0;
        end else if (!gcfg_reg.gate_toggle_mode || !ctrl_reg.timer_on) begin
            toggle_ff_reg <= 1'b0;
        end else if (pol_rise) begin
            toggle_ff_reg <= !toggle_ff_reg;
        end
    end

    // ----------------------------------------
    // Single-pulse sequencer
    // ----------------------------------------
    // The trailing edge is taken from the toggle stage when it is on
    logic sp_rise, sp_fall, tgl_prev_reg;
    assign sp_rise = gcfg_reg.gate_toggle_mode ? (toggle_ff_reg && !tgl_prev_reg) : pol_rise;
    assign sp_fall = gcfg_reg.gate_toggle_mode ? (!toggle_ff_reg && tgl_prev_reg) : pol_fall;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sp_reg <= timer_gate_pkg::SP_IDLE;
            single_pulse_arm_reg <= 1'b0;
            tgl_prev_reg <= 1'b0;
        end else begin
            tgl_prev_reg <= toggle_ff_reg;
            case (sp_reg)
                timer_gate_pkg::SP_IDLE: begin
                    if (single_pulse_arm_reg && gcfg_reg.gate_single_pulse_mode) begin
                        sp_reg <= timer_gate_pkg::SP_ARMED;
                    end
                end
                timer_gate_pkg::SP_ARMED: begin
                    if (!single_pulse_arm_reg || !gcfg_reg.gate_single_pulse_mode) begin
                        sp_reg <= timer_gate_pkg::SP_IDLE;
                    end else if (sp_rise) begin
                        sp_reg <= timer_gate_pkg::SP_ACTIVE;
                    end
                end
                timer_gate_pkg::SP_ACTIVE: begin
                    if (sp_fall || !gcfg_reg.gate_single_pulse_mode) begin
                        sp_reg <= timer_gate_pkg::SP_IDLE;
                    end
                end
                default: sp_reg <= timer_gate_pkg::SP_IDLE;
            endcase
            // Software arming wins over the hardware clear
            if (wr_gate && wstrb_reg[0]) begin
                single_pulse_arm_reg <= wdata_reg[3];
            end else if (sp_reg == timer_gate_pkg::SP_ACTIVE && sp_fall) begin
                single_pulse_arm_reg <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // Counter and flags
    // ----------------------------------------
    logic inc;        // Counter advances this cycle
    logic wrap;       // Counter wraps this cycle
    assign inc = ctrl_reg.timer_on && (!gcfg_reg.gate_enable || gate_value_reg)
              && tick && sleep_ok;
    assign wrap = inc && count_reg == timer_gate_pkg::COUNT_MAX;

    // Byte writes take precedence over a coincident increment
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            count_reg <= 16'h0000;
        end else if (wr_count && (wstrb_reg[0] || wstrb_reg[1])) begin
            if (wstrb_reg[0]) count_reg[7:0] <= wdata_reg[7:0];
            if (wstrb_reg[1]) count_reg[15:8] <= wdata_reg[15:8];
        end else if (inc) begin
            count_reg <= count_reg + 16'h0001;
        end
    end

    // Gate value status tracks the gate regardless of gate enable
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            gate_value_reg <= 1'b0;
        end else begin
            gate_value_reg <= gate_val;
        end
    end

    // Sticky flags, write one to clear, a new event beats the clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            overflow_flag_reg <= 1'b0;
            gate_event_flag_reg <= 1'b0;
        end else begin
            if (wrap) begin
                overflow_flag_reg <= 1'b1;
            end else if (wr_flag && wstrb_reg[0] && wdata_reg[1]) begin
                overflow_flag_reg <= 1'b0;
            end
            if (gate_value_reg && !gate_val) begin
                gate_event_flag_reg <= 1'b1;
            end else if (wr_flag && wstrb_reg[0] && wdata_reg[0]) begin
                gate_event_flag_reg <= 1'b0;
            end
        end
    end

    // Interrupt and wake requests to the core
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_request <= 1'b0;
            wake_request <= 1'b0;
        end else begin
            irq_request <= ien_reg.global_irq_enable && ien_reg.peripheral_irq_enable
                && ((overflow_flag_reg && ien_reg.overflow_irq_enable
                     && ctrl_reg.timer_on)
                    || (gate_event_flag_reg && ien_reg.gate_event_irq_enable));
            // Wake needs no global enable; the core resumes either way
            wake_request <= sleep_active && overflow_flag_reg && ctrl_reg.timer_on
                && ien_reg.overflow_irq_enable && ien_reg.peripheral_irq_enable;
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    chk_wrap_flag: assert property (
        wrap && !wr_count |=> overflow_flag_reg && count_reg == 16'h0000)
        else $error("wrap did not set overflow flag");
    chk_gated_hold: assert property (
        ctrl_reg.timer_on && gcfg_reg.gate_enable && !gate_value_reg && !wr_count
        |=> $stable(count_reg))
        else $error("count moved while gate inactive");
    chk_toggle_clear: assert property (
        !gcfg_reg.gate_toggle_mode |=> !toggle_ff_reg)
        else $error("toggle flip-flop not held clear");
    chk_off_stops: assert property (
        !ctrl_reg.timer_on && !wr_count |=> $stable(count_reg) && !toggle_ff_reg)
        else $error("timer off but counting");
    chk_gate_event: assert property (
        gate_value_reg && !gate_val |=> gate_event_flag_reg)
        else $error("gate fall missed");
    chk_irq_gating: assert property (
        !ien_reg.global_irq_enable |=> !irq_request)
        else $error("interrupt without global enable");
    chk_arm_done: assert property (
        sp_reg == timer_gate_pkg::SP_ACTIVE && sp_fall && !wr_gate
        |=> !single_pulse_arm_reg ##1 sp_reg == timer_gate_pkg::SP_IDLE)
        else $error("arm not cleared at trailing edge");
    chk_reserved_src: assert property (
        gate_source_select_reg == 2'b11 |-> !src_lvl)
        else $error("reserved source passed a level");
    chk_sleep_hold: assert property (
        sleep_active && !ctrl_reg.no_sync_control && !wr_count |=> $stable(count_reg))
        else $error("synchronised counter ran in sleep");

endmodule

// >>> rtl/timer_gate_pkg.sv
// Functional notes
// - Byte reads return stable count values
// - Gate enable and polarity control counting
// - Gated counter counts only at active level
// - Two-bit select picks pin, overflow, comparator
// - Companion wrap FFh to 00h makes pulse
// - Comparator gate synchronized or left raw
// - Toggle flip-flop flips on incrementing edge
// - Toggle flip-flop held clear when disabled
// - Arm, count from edge, clear at trailing
// - No counting after pulse until rearmed
// - Toggle and single-pulse work together
// - Gate value status always readable
// - Gate value fall sets gate event flag
// - Gate event flag works without gate enable
// - Wrap FFFFh to 0000h sets overflow flag
// - Overflow interrupt needs four enable bits
// - Sleep counts only unsynchronized external; wakes
// - Timer off stops count, clears flip-flop
package timer_gate_pkg;

    // ----------------------------------------
    // Register map (byte addresses)
    // ----------------------------------------
    localparam int unsigned ADDR_W = 5;
    localparam logic [4:0] CTRL_OFS = 5'h00;
    localparam logic [4:0] GATE_OFS = 5'h04;
    localparam logic [4:0] COUNT_OFS = 5'h08;
    localparam logic [4:0] FLAG_OFS = 5'h0C;
    localparam logic [4:0] IEN_OFS = 5'h10;

    // ----------------------------------------
    // Constants
    // ----------------------------------------
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [1:0] GSS_PIN = 2'h0;
    localparam logic [1:0] GSS_COMPANION = 2'h1;
    localparam logic [1:0] GSS_COMPARATOR = 2'h2;
    localparam logic [7:0] COMPANION_MAX = 8'hFF;
    localparam logic [15:0] COUNT_MAX = 16'hFFFF;

    // ----------------------------------------
    // Field layouts, within the low byte of each word
    // ----------------------------------------
    typedef struct packed {
        logic comp_sync;        // bit 3
        logic no_sync_control;  // bit 2
        logic clock_source_select; // bit 1, 1 = external pin
        logic timer_on;         // bit 0
    } ctrl_t;
    typedef struct packed {
        logic gate_enable;      // bit 7
        logic gate_polarity;    // bit 6
        logic gate_toggle_mode; // bit 5
        logic gate_single_pulse_mode; // bit 4
    } gate_cfg_t;
    typedef struct packed {
        logic global_irq_enable;     // bit 3
        logic peripheral_irq_enable; // bit 2
        logic overflow_irq_enable;   // bit 1
        logic gate_event_irq_enable; // bit 0
    } irq_en_t;

    // Single-pulse sequencer
    typedef enum logic [2:0] {
        SP_IDLE = 3'b001,
        SP_ARMED = 3'b010,
        SP_ACTIVE = 3'b100
    } sp_state_t;

endpackage

// >>> verif/tb.sv
`timescale 1ns/1ps
module tb;
    // ----------------------------------------
    // Stimulus and observed signals
    // ----------------------------------------
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [4:0] s_axi_awaddr = 5'h00, s_axi_araddr = 5'h00;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b1;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b1;
    logic [31:0] s_axi_wdata = 32'h0000_0000;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata, rd_a, rd_b;
    logic gate_pin = 1'b0, comparator_gate_output = 1'b0, ext_clock_pin = 1'b0;
    logic [7:0] companion_8bit_timer = 8'h10;
    logic sleep_active = 1'b0;
    logic irq_request, wake_request;
    logic [1:0] resp;
    int fails = 0, n_compared = 0;

    // Clock of 20 ns
    always #10 aclk = ~aclk;

    gated_sixteen_bit_timer i_gated_sixteen_bit_timer (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .gate_pin(gate_pin),
        .comparator_gate_output(comparator_gate_output), .ext_clock_pin(ext_clock_pin),
        .companion_8bit_timer(companion_8bit_timer), .sleep_active(sleep_active),
        .irq_request(irq_request), .wake_request(wake_request));

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic finish_test();
        $display("compared %0d, mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // Compare and count; an unknown bit matches only an unknown bit
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: %s got %h expected %h", $time, msg, got, exp);
        end
    endtask
    // Bounded wait ran out: count it and close
    task automatic hang();
        fails++;
        $display("unexpected at %0t: bus wait ran out", $time);
        finish_test();
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge aclk);
    endtask
    // Write: address and data offered together, each dropped once taken
    task automatic wr(input logic [4:0] a, input logic [31:0] d, output logic [1:0] r);
        int n;
        s_axi_awaddr <= a; s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1; s_axi_wvalid <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid === 1'b1) break;
        end
        if (n == 50) hang();
        r = s_axi_bresp;
    endtask
    // Write expected to be accepted
    task automatic w(input logic [4:0] a, input logic [31:0] d);
        wr(a, d, resp);
        chk({30'h0, resp}, {30'h0, timer_gate_pkg::RESP_OKAY}, "write response");
    endtask
    // Read: arvalid held until taken, then wait for rvalid
    task automatic rd(input logic [4:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        s_axi_araddr <= a; s_axi_arvalid <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid === 1'b1) break;
        end
        if (n == 50) hang();
        d = s_axi_rdata; r = s_axi_rresp;
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    // Reset values, then unmapped places refused
    task automatic t_reset();
        rd(timer_gate_pkg::COUNT_OFS, rd_a, resp);
        chk(rd_a, 32'h0000_0000, "count after reset");
        rd(timer_gate_pkg::FLAG_OFS, rd_a, resp);
        chk(rd_a, 32'h0000_0000, "flags after reset");
        rd(5'h14, rd_a, resp);
        chk({30'h0, resp}, {30'h0, timer_gate_pkg::RESP_SLVERR}, "unmapped read");
        wr(5'h14, 32'h0000_00FF, resp);
        chk({30'h0, resp}, {30'h0, timer_gate_pkg::RESP_SLVERR}, "unmapped write");
        $display("test reset done");
    endtask
    // Wrap sets the flag; interrupt needs all four enables; stop holds count
    task automatic t_overflow();
        w(timer_gate_pkg::COUNT_OFS, 32'h0000_FFFC);
        w(timer_gate_pkg::CTRL_OFS, 32'h0000_0001);
        cyc(10);
        w(timer_gate_pkg::CTRL_OFS, 32'h0000_0000);
        rd(timer_gate_pkg::FLAG_OFS, rd_a, resp);
        chk(rd_a & 32'h0000_0002, 32'h0000_0002, "overflow flag");
        w(timer_gate_pkg::IEN_OFS, 32'h0000_000E);
        cyc(3);
        chk({31'h0, irq_request}, 32'h0000_0000, "irq with timer off");
        w(timer_gate_pkg::CTRL_OFS, 32'h0000_0001);
        cyc(3);
        chk({31'h0, irq_request}, 32'h0000_0001, "irq all enabled");
        w(timer_gate_pkg::IEN_OFS, 32'h0000_0006);
        cyc(3);
        chk({31'h0, irq_request}, 32'h0000_0000, "irq without global");
        w(timer_gate_pkg::CTRL_OFS, 32'h0000_0000);
        w(timer_gate_pkg::FLAG_OFS, 32'h0000_0003);
        rd(timer_gate_pkg::COUNT_OFS, rd_a, resp);
        cyc(10);
        rd(timer_gate_pkg::COUNT_OFS, rd_b, resp);
        chk(rd_b, rd_a, "count held when off");
        chk({24'h0, rd_a[15:8]}, 32'h0000_0000, "count wrapped to low values");
        $display("test overflow done");
    endtask
    // Status and event flag with gate disabled, then gated counting per source
    task automatic t_gate();
        int s;
        w(timer_gate_pkg::GATE_OFS, 32'h0000_0040);
        gate_pin <= 1'b1;
        cyc(8);
        rd(timer_gate_pkg::GATE_OFS, rd_a, resp);
        chk(rd_a & 32'h0000_0004, 32'h0000_0004, "gate value high");
        w(timer_gate_pkg::FLAG_OFS, 32'h1);
        gate_pin <= 1'b0;
        cyc(8);
        rd(timer_gate_pkg::FLAG_OFS, rd_a, resp);
        chk(rd_a & 32'h0000_0001, 32'h0000_0001, "gate event flag");
        for (s = 0; s < 4; s++) begin
            w(timer_gate_pkg::GATE_OFS, s == 3 ? 32'h0000_00D8 : 32'h0000_00C0 | s);
            w(timer_gate_pkg::CTRL_OFS, 32'h0000_0001);
            cyc(6);
            rd(timer_gate_pkg::COUNT_OFS, rd_a, resp);
            cyc(10);
            rd(timer_gate_pkg::COUNT_OFS, rd_b, resp);
            chk(rd_b, rd_a, "count held, gate inactive");
            if (s % 3 == 0) gate_pin <= 1'b1;
            if (s == 1) companion_8bit_timer <= timer_gate_pkg::COMPANION_MAX;
            if (s == 2) comparator_gate_output <= 1'b1;
            cyc(1);
            if (s == 1) companion_8bit_timer <= 8'h00;
            cyc(12);
            gate_pin <= 1'b0; comparator_gate_output <= 1'b0;
            w(timer_gate_pkg::CTRL_OFS, 32'h0000_0000);
            rd(timer_gate_pkg::COUNT_OFS, rd_b, resp);
            chk({31'h0, rd_b != rd_a}, 32'h0000_0001, "count advanced, gate active");
        end
        gate_pin <= 1'b1;
        cyc(8);
        rd(timer_gate_pkg::GATE_OFS, rd_a, resp);
        chk(rd_a & 32'hC, 32'h0, "single pulse done");
        $display("test gate done");
    endtask
    // Sleep: internal clock holds, unsynchronised external wraps and wakes
    task automatic t_sleep();
        w(timer_gate_pkg::GATE_OFS, 32'h0000_0000);
        w(timer_gate_pkg::FLAG_OFS, 32'h0000_0003);
        w(timer_gate_pkg::COUNT_OFS, 32'h0000_FFFE);
        w(timer_gate_pkg::IEN_OFS, 32'h0000_0006);
        sleep_active <= 1'b1;
        w(timer_gate_pkg::CTRL_OFS, 32'h0000_0001);
        cyc(10);
        rd(timer_gate_pkg::COUNT_OFS, rd_a, resp);
        chk(rd_a, 32'h0000_FFFE, "internal clock stops in sleep");
        w(timer_gate_pkg::CTRL_OFS, 32'h0000_0007);
        chk({31'h0, wake_request}, 32'h0000_0000, "no wake before wrap");
        repeat (3) begin
            ext_clock_pin <= 1'b1;
            cyc(4);
            ext_clock_pin <= 1'b0;
            cyc(4);
        end
        cyc(4);
        chk({31'h0, wake_request}, 32'h0000_0001, "wake on wrap in sleep");
        sleep_active <= 1'b0;
        $display("test sleep done");
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        cyc(10);
        aresetn <= 1'b1;
        t_reset();
        t_overflow();
        t_gate();
        t_sleep();
        finish_test();
    end
endmodule
